// file: hw/fcm_pkg.sv
// constants of the feature configuration register bank
// assumes a 64-bit register port addressed by 32-bit register numbers
package fcm_pkg;
    // register numbers
    localparam logic [31:0] FCM_ADDR_EXT_FEAT = 32'hC000_0080;
    localparam logic [31:0] FCM_ADDR_SYS_CFG = 32'hC001_0010;
    localparam logic [31:0] FCM_ADDR_HW_CFG = 32'hC001_0015;
    // extended feature enable fields
    localparam int FCM_EXT_SCE = 0;
    localparam int FCM_EXT_LME = 8;
    localparam int FCM_EXT_LMA = 10;
    localparam int FCM_EXT_NXE = 11;
    localparam int FCM_EXT_SVM = 12;
    localparam int FCM_EXT_LMSL = 13;
    localparam int FCM_EXT_FSR = 14;
    // system configuration fields
    localparam int FCM_SYS_ACK_LSB = 0;
    localparam int FCM_SYS_ACK_W = 5;
    localparam int FCM_SYS_VIC_LSB = 5;
    localparam int FCM_SYS_VIC_W = 3;
    localparam int FCM_SYS_PRB_E = 8;
    localparam int FCM_SYS_PRB_S = 9;
    localparam int FCM_SYS_PRB_O = 10;
    localparam int FCM_SYS_CTD_DIS = 16;
    localparam int FCM_SYS_LOCK = 17;
    localparam int FCM_SYS_FIX_EN = 18;
    localparam int FCM_SYS_FIX_MOD = 19;
    localparam int FCM_SYS_VAR_EN = 20;
    localparam int FCM_SYS_SECOND_TOP_OF_MEMORY_EN = 21;
    localparam int FCM_SYS_SECOND_TOP_OF_MEMORY_WB = 22;
    // hardware configuration fields
    localparam int FCM_HW_TLB_CD = 3;
    localparam int FCM_HW_WRAP_DIS = 17;
    localparam int FCM_HW_MC_WREN = 18;
    // reset values
    localparam logic [63:0] FCM_EXT_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FCM_SYS_RST = 64'h0000_0000_0002_0601;
    localparam logic [63:0] FCM_HW_RST = 64'h0000_0000_0000_0000;
    // bits software may change; all others read as zero or status
    localparam logic [63:0] FCM_EXT_WMASK = 64'h0000_0000_0000_7901;
    localparam logic [63:0] FCM_SYS_WMASK = 64'h0000_0000_007F_07FF;
    localparam logic [63:0] FCM_HW_WMASK = 64'h0000_0000_0006_0008;
    // fault error code
    localparam logic [15:0] FCM_GP_ERR_CODE = 16'h0000;
    // 4 gigabyte boundary
    localparam logic [63:0] FCM_FOUR_GB = 64'h0000_0001_0000_0000;
    // cache line state before an upgrade to modified
    typedef enum logic [1:0] {
        FCM_LINE_EXCL = 2'b00,
        FCM_LINE_SHARED = 2'b01,
        FCM_LINE_OWNED = 2'b10,
        FCM_LINE_OTHER = 2'b11
    } fcm_line_state_type;
endpackage

// file: hw/fcm_addr_if.sv
// address forming signals between the register bank and its address former
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface fcm_addr_if;
    logic [63:0] seg_base;
    logic [31:0] offset;
    logic legacy;
    logic narrow_insn;
    logic wrap_dis;
    logic [63:0] lin_addr;
    modport bank (output seg_base, output offset, output legacy, output narrow_insn,
        output wrap_dis, input lin_addr);
    modport former (input seg_base, input offset, input legacy, input narrow_insn,
        input wrap_dis, output lin_addr);
endinterface

// file: hw/fcm_addr_former.sv
// legacy mode linear address former steered by the wrap disable bit
// assumes the core clock and synchronous active low reset
`timescale 1ns/1ps
module fcm_addr_former
    import fcm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    fcm_addr_if.former addr
);
    logic [63:0] next_lin;
    logic [63:0] off_sx;

    // wide form uses the whole base plus a signed offset of +-2 gigabytes
    always_comb begin
        off_sx = {{32{addr.offset[31]}}, addr.offset};
        if (addr.legacy && addr.wrap_dis && !addr.narrow_insn) begin
            next_lin = addr.seg_base + off_sx;
        end else begin
            next_lin = {32'h0000_0000, addr.seg_base[31:0] + addr.offset};
        end
    end

    // registered result
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            addr.lin_addr <= 64'h0000_0000_0000_0000;
        end else begin
            addr.lin_addr <= next_lin;
        end
    end

    a_wrap_narrow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        addr.narrow_insn |=> addr.lin_addr[63:32] == 32'h0000_0000)
        else $error("narrow store formed a wide address");
endmodule

// file: hw/fcm_msr_bank.sv
// feature, system and hardware configuration register bank of the core
// assumes one register request at a time from the privileged instruction path
//
// Behaviour
// - writing a long-mode-active value different from current faults, code zero, no update
// - bit 0 enables system call extension, read-write, resets zero
// - bit 8 long mode enable read-write; bit 10 read-only active status
// - bit 11 enables no-execute page protection, resets zero
// - bit 12 virtualization enable, bit 13 long-mode segment limits, reset zero
// - bits 4..0 cap outstanding bus commands, reset 00001b
// - bits 7..5 cap outstanding victim commands, reset 000b
// - bits 8,9,10 enable probes from E,S,O to M; reset 0,1,1
// - bit 16 set: no change-to-dirty, evict line from data cache instead
// - bit 17 enables interface lock commands, resets one
// - bit 18 enables fixed-range dram attributes, resets zero
// - bit 19 gates software changes to fixed-range dram attributes
// - bit 20 enables top-of-memory and io range registers
// - bit 21 enables second top-of-memory register, resets zero
// - bit 22 with default type enable: 4GB..limit defaults to write-back
// - wrap disable gives wide legacy addresses, except narrow store forms
// - status write enable lets nonzero machine-check writes pass unfaulted
`timescale 1ns/1ps
module fcm_msr_bank
    import fcm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic msr_rd_i,
    input wire logic msr_wr_i,
    input wire logic [31:0] msr_addr_i,
    input wire logic [63:0] msr_wdata_i,
    output logic msr_ack_o,
    output logic [63:0] msr_rdata_o,
    output logic gp_fault_o,
    output logic [15:0] gp_err_code_o,
    input wire logic long_mode_active_i,
    output logic system_call_ext_enable_o,
    output logic long_mode_enable_o,
    output logic long_mode_active_flag_o,
    output logic no_execute_page_enable_o,
    output logic virtualization_enable_o,
    output logic long_segment_limit_enable_o,
    output logic fast_save_restore_enable_o,
    input wire logic [4:0] bus_cmd_outstanding_i,
    input wire logic [2:0] victim_cmd_outstanding_i,
    output logic bus_cmd_issue_ok_o,
    output logic victim_cmd_issue_ok_o,
    input wire logic upgrade_req_i,
    input wire logic [1:0] upgrade_from_i,
    output logic write_probe_o,
    output logic change_to_dirty_o,
    output logic evict_line_o,
    output logic interface_lock_cmd_enable_o,
    output logic fixed_range_dram_attr_enable_o,
    input wire logic fixed_attr_wr_i,
    output logic fixed_attr_wr_ok_o,
    output logic top_mem_and_io_range_enable_o,
    output logic second_top_mem_enable_o,
    input wire logic default_memory_type_enable_i,
    input wire logic [63:0] second_top_of_memory_i,
    input wire logic [63:0] phys_addr_i,
    output logic high_memory_writeback_o,
    input wire logic [63:0] seg_base_i,
    input wire logic [31:0] seg_offset_i,
    input wire logic legacy_mode_i,
    input wire logic narrow_store_i,
    output logic [63:0] linear_addr_o,
    input wire logic mc_wr_i,
    input wire logic mc_wdata_nonzero_i,
    output logic mc_wr_fault_o,
    output logic mc_wr_update_o,
    output logic page_table_cacheable_disable_o
);
    logic [63:0] ext_feat;
    logic [63:0] sys_cfg;
    logic [63:0] hw_cfg;
    logic hit_ext;
    logic hit_sys;
    logic hit_hw;
    logic hit_any;
    logic lma_change;
    logic wr_fault;
    logic [63:0] ext_view;
    logic [63:0] next_rdata;
    fcm_line_state_type from_state;

    fcm_addr_if addr_bus ();

    // address decode
    assign hit_ext = (msr_addr_i == FCM_ADDR_EXT_FEAT);
    assign hit_sys = (msr_addr_i == FCM_ADDR_SYS_CFG);
    assign hit_hw = (msr_addr_i == FCM_ADDR_HW_CFG);
    assign hit_any = hit_ext | hit_sys | hit_hw;

    // a write that tries to move the status flag is refused
    assign lma_change = msr_wdata_i[FCM_EXT_LMA] != ext_feat[FCM_EXT_LMA];
    assign wr_fault = msr_wr_i && ((hit_ext && lma_change) || !hit_any);

    // status flag tracks the core, software cannot move it
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ext_feat <= FCM_EXT_RST;
        end else begin
            ext_feat[FCM_EXT_LMA] <= long_mode_active_i;
            if (msr_wr_i && hit_ext && !lma_change) begin
                ext_feat[FCM_EXT_SCE] <= msr_wdata_i[FCM_EXT_SCE];
                ext_feat[FCM_EXT_LME] <= msr_wdata_i[FCM_EXT_LME];
                ext_feat[FCM_EXT_NXE] <= msr_wdata_i[FCM_EXT_NXE];
                ext_feat[FCM_EXT_SVM] <= msr_wdata_i[FCM_EXT_SVM];
                ext_feat[FCM_EXT_LMSL] <= msr_wdata_i[FCM_EXT_LMSL];
                ext_feat[FCM_EXT_FSR] <= msr_wdata_i[FCM_EXT_FSR];
            end
        end
    end

    // system configuration, only implemented fields are stored
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sys_cfg <= FCM_SYS_RST;
        end else if (msr_wr_i && hit_sys) begin
            sys_cfg <= msr_wdata_i & FCM_SYS_WMASK;
        end
    end

    // hardware configuration, covered fields only
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hw_cfg <= FCM_HW_RST;
        end else if (msr_wr_i && hit_hw) begin
            hw_cfg <= msr_wdata_i & FCM_HW_WMASK;
        end
    end

    // read view: reserved bits forced to zero
    assign ext_view = ext_feat & (FCM_EXT_WMASK | (64'h1 << FCM_EXT_LMA));

    always_comb begin
        next_rdata = 64'h0000_0000_0000_0000;
        if (msr_rd_i) begin
            if (hit_ext) begin
                next_rdata = ext_view;
            end else if (hit_sys) begin
                next_rdata = sys_cfg;
            end else if (hit_hw) begin
                next_rdata = hw_cfg;
            end
        end
    end

    // one-cycle answer to each request
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            msr_ack_o <= 1'b0;
            msr_rdata_o <= 64'h0000_0000_0000_0000;
            gp_fault_o <= 1'b0;
            gp_err_code_o <= FCM_GP_ERR_CODE;
        end else begin
            msr_ack_o <= msr_rd_i | msr_wr_i;
            msr_rdata_o <= next_rdata;
            gp_fault_o <= wr_fault | (msr_rd_i && !hit_any);
            gp_err_code_o <= FCM_GP_ERR_CODE;
        end
    end

    // feature enables driven to the core
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            system_call_ext_enable_o <= 1'b0;
            long_mode_enable_o <= 1'b0;
            long_mode_active_flag_o <= 1'b0;
            no_execute_page_enable_o <= 1'b0;
            virtualization_enable_o <= 1'b0;
            long_segment_limit_enable_o <= 1'b0;
            fast_save_restore_enable_o <= 1'b0;
        end else begin
            system_call_ext_enable_o <= ext_feat[FCM_EXT_SCE];
            long_mode_enable_o <= ext_feat[FCM_EXT_LME];
            long_mode_active_flag_o <= ext_feat[FCM_EXT_LMA];
            no_execute_page_enable_o <= ext_feat[FCM_EXT_NXE];
            virtualization_enable_o <= ext_feat[FCM_EXT_SVM];
            long_segment_limit_enable_o <= ext_feat[FCM_EXT_LMSL];
            fast_save_restore_enable_o <= ext_feat[FCM_EXT_FSR];
        end
    end

    // bus command throttles and upgrade handling
    assign from_state = fcm_line_state_type'(upgrade_from_i);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus_cmd_issue_ok_o <= 1'b0;
            victim_cmd_issue_ok_o <= 1'b0;
            write_probe_o <= 1'b0;
            change_to_dirty_o <= 1'b0;
            evict_line_o <= 1'b0;
        end else begin
            bus_cmd_issue_ok_o <= bus_cmd_outstanding_i <
                sys_cfg[FCM_SYS_ACK_LSB +: FCM_SYS_ACK_W];
            victim_cmd_issue_ok_o <= victim_cmd_outstanding_i <
                sys_cfg[FCM_SYS_VIC_LSB +: FCM_SYS_VIC_W];
            write_probe_o <= 1'b0;
            change_to_dirty_o <= 1'b0;
            evict_line_o <= 1'b0;
            if (upgrade_req_i) begin
                case (from_state)
                    FCM_LINE_EXCL: write_probe_o <= sys_cfg[FCM_SYS_PRB_E];
                    FCM_LINE_SHARED: write_probe_o <= sys_cfg[FCM_SYS_PRB_S];
                    FCM_LINE_OWNED: write_probe_o <= sys_cfg[FCM_SYS_PRB_O];
                    default: write_probe_o <= 1'b0;
                endcase
                change_to_dirty_o <= !sys_cfg[FCM_SYS_CTD_DIS];
                evict_line_o <= sys_cfg[FCM_SYS_CTD_DIS];
            end
        end
    end

    // memory range controls
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            interface_lock_cmd_enable_o <= 1'b1;
            fixed_range_dram_attr_enable_o <= 1'b0;
            fixed_attr_wr_ok_o <= 1'b0;
            top_mem_and_io_range_enable_o <= 1'b0;
            second_top_mem_enable_o <= 1'b0;
            high_memory_writeback_o <= 1'b0;
        end else begin
            interface_lock_cmd_enable_o <= sys_cfg[FCM_SYS_LOCK];
            fixed_range_dram_attr_enable_o <= sys_cfg[FCM_SYS_FIX_EN];
            fixed_attr_wr_ok_o <= fixed_attr_wr_i && sys_cfg[FCM_SYS_FIX_MOD];
            top_mem_and_io_range_enable_o <= sys_cfg[FCM_SYS_VAR_EN];
            second_top_mem_enable_o <= sys_cfg[FCM_SYS_SECOND_TOP_OF_MEMORY_EN];
            high_memory_writeback_o <= sys_cfg[FCM_SYS_SECOND_TOP_OF_MEMORY_WB] && default_memory_type_enable_i
                && phys_addr_i >= FCM_FOUR_GB && phys_addr_i < second_top_of_memory_i;
        end
    end

    // hardware configuration effects
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mc_wr_fault_o <= 1'b0;
            mc_wr_update_o <= 1'b0;
            page_table_cacheable_disable_o <= 1'b0;
        end else begin
            mc_wr_fault_o <= mc_wr_i && mc_wdata_nonzero_i && !hw_cfg[FCM_HW_MC_WREN];
            mc_wr_update_o <= mc_wr_i && (hw_cfg[FCM_HW_MC_WREN] || !mc_wdata_nonzero_i);
            page_table_cacheable_disable_o <= hw_cfg[FCM_HW_TLB_CD];
        end
    end

    // address former fed from the core and the wrap disable bit
    assign addr_bus.seg_base = seg_base_i;
    assign addr_bus.offset = seg_offset_i;
    assign addr_bus.legacy = legacy_mode_i;
    assign addr_bus.narrow_insn = narrow_store_i;
    assign addr_bus.wrap_dis = hw_cfg[FCM_HW_WRAP_DIS];
    assign linear_addr_o = addr_bus.lin_addr;

    fcm_addr_former u_former (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .addr(addr_bus.former)
    );

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_lma_guard: assert property (msr_wr_i && hit_ext && lma_change |=> gp_fault_o)
        else $error("status flag change not faulted");
    a_lma_hold: assert property (msr_wr_i && hit_ext && lma_change
        |=> ext_feat[FCM_EXT_SCE] == $past(ext_feat[FCM_EXT_SCE]))
        else $error("faulting write updated the register");
    a_sce_write: assert property (msr_wr_i && hit_ext && !lma_change
        |=> ##1 system_call_ext_enable_o == $past(msr_wdata_i[FCM_EXT_SCE], 2))
        else $error("system call enable not written");
    a_lma_track: assert property (##1 ##1 long_mode_active_flag_o == $past(long_mode_active_i, 2))
        else $error("status flag does not follow the core");
    a_ack_limit: assert property (bus_cmd_issue_ok_o
        |-> $past(bus_cmd_outstanding_i) < $past(sys_cfg[4:0]))
        else $error("bus command allowed beyond the limit");
    a_ctd_evict: assert property (upgrade_req_i && sys_cfg[FCM_SYS_CTD_DIS]
        |=> evict_line_o && !change_to_dirty_o)
        else $error("change to dirty issued while disabled");
    a_fix_gate: assert property (fixed_attr_wr_i && !sys_cfg[FCM_SYS_FIX_MOD]
        |=> !fixed_attr_wr_ok_o)
        else $error("attribute change allowed while locked");
    a_mc_wren: assert property (mc_wr_i && hw_cfg[FCM_HW_MC_WREN] |=> !mc_wr_fault_o)
        else $error("machine check write faulted while enabled");
    a_rsvd_zero: assert property (msr_ack_o |-> msr_rdata_o[63:23] == 41'h0)
        else $error("reserved bits read nonzero");
    a_rst_sys: assert property ($rose(rst_n_i) |-> sys_cfg == FCM_SYS_RST)
        else $error("system configuration reset value wrong");

    c_lma_fault: cover property (msr_wr_i && hit_ext && lma_change ##1 gp_fault_o);
    c_evict: cover property (upgrade_req_i && sys_cfg[FCM_SYS_CTD_DIS] ##1 evict_line_o);
    c_read_sys: cover property (msr_rd_i && hit_sys ##1 msr_ack_o);
    c_fix_write: cover property (fixed_attr_wr_i && sys_cfg[FCM_SYS_FIX_MOD] ##1 fixed_attr_wr_ok_o);
    c_mc_pass: cover property (mc_wr_i && mc_wdata_nonzero_i && hw_cfg[FCM_HW_MC_WREN] ##1 mc_wr_update_o);

    a_probe_other: assert property (upgrade_req_i && upgrade_from_i == 2'b11 |=> !write_probe_o)
        else $error("write probe raised for an unlisted line state");
endmodule

// file: test/fcm_msr_bank_tb_top.sv
// self-checking bench of the feature configuration register bank
// assumes answers one cycle after a request is taken and registered core-side results
`timescale 1ns/1ps
module fcm_msr_bank_tb_top
    import fcm_pkg::*;
;
    logic mclk_i = 1'h0;
    logic rst_n_i, msr_rd_i, msr_wr_i, long_mode_active_i, upgrade_req_i, fixed_attr_wr_i;
    logic default_memory_type_enable_i, legacy_mode_i, narrow_store_i, mc_wr_i, mc_wdata_nonzero_i;
    logic [31:0] msr_addr_i, seg_offset_i;
    logic [63:0] msr_wdata_i, second_top_of_memory_i, phys_addr_i, seg_base_i;
    logic [4:0] bus_cmd_outstanding_i;
    logic [2:0] victim_cmd_outstanding_i;
    logic [1:0] upgrade_from_i;
    logic msr_ack_o, gp_fault_o, system_call_ext_enable_o, long_mode_enable_o;
    logic long_mode_active_flag_o, no_execute_page_enable_o, virtualization_enable_o;
    logic long_segment_limit_enable_o, fast_save_restore_enable_o, bus_cmd_issue_ok_o;
    logic victim_cmd_issue_ok_o, write_probe_o, change_to_dirty_o, evict_line_o;
    logic interface_lock_cmd_enable_o, fixed_range_dram_attr_enable_o, fixed_attr_wr_ok_o;
    logic top_mem_and_io_range_enable_o, second_top_mem_enable_o, high_memory_writeback_o;
    logic mc_wr_fault_o, mc_wr_update_o, page_table_cacheable_disable_o;
    logic [63:0] msr_rdata_o, linear_addr_o;
    logic [15:0] gp_err_code_o;
    // bench copies of the registers and expectation queues
    logic [63:0] ext, sys, hw;
    logic long_mode_active_flag, core_mark, core_d;
    logic [80:0] q_ans[$];
    logic [72:0] q_core[$];
    int fails, n_checks, cycles, seed;

    fcm_msr_bank dut (.mclk_i, .rst_n_i, .msr_rd_i, .msr_wr_i, .msr_addr_i, .msr_wdata_i,
        .msr_ack_o, .msr_rdata_o, .gp_fault_o, .gp_err_code_o, .long_mode_active_i,
        .system_call_ext_enable_o, .long_mode_enable_o, .long_mode_active_flag_o,
        .no_execute_page_enable_o, .virtualization_enable_o, .long_segment_limit_enable_o,
        .fast_save_restore_enable_o, .bus_cmd_outstanding_i, .victim_cmd_outstanding_i,
        .bus_cmd_issue_ok_o, .victim_cmd_issue_ok_o, .upgrade_req_i, .upgrade_from_i,
        .write_probe_o, .change_to_dirty_o, .evict_line_o, .interface_lock_cmd_enable_o,
        .fixed_range_dram_attr_enable_o, .fixed_attr_wr_i, .fixed_attr_wr_ok_o,
        .top_mem_and_io_range_enable_o, .second_top_mem_enable_o,
        .default_memory_type_enable_i, .second_top_of_memory_i, .phys_addr_i,
        .high_memory_writeback_o, .seg_base_i, .seg_offset_i, .legacy_mode_i, .narrow_store_i,
        .linear_addr_o, .mc_wr_i, .mc_wdata_nonzero_i, .mc_wr_fault_o, .mc_wr_update_o,
        .page_table_cacheable_disable_o);

    // core clock, 25 ns period
    always #12.5 mclk_i = ~mclk_i;

    task automatic bad(input string msg);
        $display("BAD %0t %s", $time, msg);
        fails++;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // compare one register answer: fault, error code, read data
    task automatic cmp_ans(input logic [80:0] got, input logic [80:0] exp);
        n_checks++;
        if (got !== exp) bad($sformatf("answer %h expected %h", got, exp));
    endtask

    // compare a vector of core-side outputs
    task automatic cmp_out(input logic [72:0] got, input logic [72:0] exp);
        n_checks++;
        if (got !== exp) bad($sformatf("outputs %h expected %h", got, exp));
    endtask

    // one register request; strobes stay up so requests can run back to back
    task automatic reg_op(input logic wr, input logic [31:0] a, input logic [63:0] d);
        logic f;
        logic [63:0] rd;
        f = 1'h0;
        rd = 64'h0;
        if (wr && a == FCM_ADDR_EXT_FEAT) begin
            f = (d[10] !== long_mode_active_flag);
            if (!f) ext = d & 64'h7901;
        end else if (wr && a == FCM_ADDR_SYS_CFG) begin
            sys = d & 64'h7F_07FF;
        end else if (wr && a == FCM_ADDR_HW_CFG) begin
            hw = d & 64'h6_0008;
        end else if (!wr && a == FCM_ADDR_EXT_FEAT) begin
            rd = ext | {53'h0, long_mode_active_flag, 10'h0};
        end else if (!wr && a == FCM_ADDR_SYS_CFG) begin
            rd = sys;
        end else if (!wr && a == FCM_ADDR_HW_CFG) begin
            rd = hw;
        end else begin
            f = 1'h1;
        end
        msr_rd_i <= !wr;
        msr_wr_i <= wr;
        msr_addr_i <= a;
        msr_wdata_i <= d;
        q_ans.push_back({f, 16'h0, rd});
        @(posedge mclk_i);
    endtask

    // drop every strobe and let n edges pass
    task automatic idle(input int n);
        msr_rd_i <= 1'h0;
        msr_wr_i <= 1'h0;
        upgrade_req_i <= 1'h0;
        fixed_attr_wr_i <= 1'h0;
        mc_wr_i <= 1'h0;
        core_mark <= 1'h0;
        repeat (n) @(posedge mclk_i);
    endtask

    // one random cycle of core-side traffic with its expected registered results
    task automatic core_step();
        logic [31:0] r, off;
        logic [63:0] pa, base, lin;
        logic prb, flt, wb;
        r = $random(seed);
        pa = {31'h0, r[16], 32'($random(seed))};
        base = {32'($random(seed)), 32'($random(seed))};
        off = $random(seed);
        case (r[2:1])
            FCM_LINE_EXCL: prb = sys[8];
            FCM_LINE_SHARED: prb = sys[9];
            FCM_LINE_OWNED: prb = sys[10];
            default: prb = 1'h0;
        endcase
        if (r[6] && hw[17] && !r[7]) lin = base + {{32{off[31]}}, off};
        else lin = {32'h0, base[31:0] + off};
        flt = r[4] & r[5] & !hw[18];
        wb = sys[22] & r[17] & (pa >= 64'h1_0000_0000) & (pa < second_top_of_memory_i);
        upgrade_req_i <= r[0];
        upgrade_from_i <= r[2:1];
        fixed_attr_wr_i <= r[3];
        mc_wr_i <= r[4];
        mc_wdata_nonzero_i <= r[5];
        legacy_mode_i <= r[6];
        narrow_store_i <= r[7];
        bus_cmd_outstanding_i <= r[12:8];
        victim_cmd_outstanding_i <= r[15:13];
        default_memory_type_enable_i <= r[17];
        phys_addr_i <= pa;
        seg_base_i <= base;
        seg_offset_i <= off;
        core_mark <= 1'h1;
        q_core.push_back({r[0] & prb, r[0] & !sys[16], r[0] & sys[16], r[3] & sys[19], flt,
            r[4] & !flt, wb, r[12:8] < sys[4:0], r[15:13] < sys[7:5], lin});
        @(posedge mclk_i);
    endtask

    // level outputs against the bench copies
    task automatic chk_levels();
        cmp_out(73'({system_call_ext_enable_o, long_mode_enable_o, long_mode_active_flag_o,
            no_execute_page_enable_o, virtualization_enable_o, long_segment_limit_enable_o,
            fast_save_restore_enable_o, interface_lock_cmd_enable_o,
            fixed_range_dram_attr_enable_o, top_mem_and_io_range_enable_o,
            second_top_mem_enable_o, page_table_cacheable_disable_o}),
            73'({ext[0], ext[8], long_mode_active_flag, ext[11], ext[12], ext[13], ext[14], sys[17], sys[18],
            sys[20], sys[21], hw[3]}));
    endtask

    // result watcher: takes the oldest note whenever a result appears
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 8000) begin
            bad("run did not finish");
            end_of_test();
        end else begin
            if (msr_ack_o === 1'h1) begin
                if (q_ans.size() == 0) bad("answer with none awaited");
                else cmp_ans({gp_fault_o, gp_err_code_o, msr_rdata_o},
                    q_ans.pop_front());
            end
            if (core_d === 1'h1) begin
                if (q_core.size() == 0) bad("core result with none awaited");
                else cmp_out({write_probe_o, change_to_dirty_o, evict_line_o,
                    fixed_attr_wr_ok_o, mc_wr_fault_o, mc_wr_update_o, high_memory_writeback_o,
                    bus_cmd_issue_ok_o, victim_cmd_issue_ok_o, linear_addr_o},
                    q_core.pop_front());
            end
            core_d <= core_mark;
        end
    end

    initial begin
        seed = 32'h95B7FAA5;
        fails = 0;
        n_checks = 0;
        rst_n_i = 1'h0;
        long_mode_active_i = 1'h0;
        msr_addr_i = 32'h0;
        msr_wdata_i = 64'h0;
        second_top_of_memory_i = 64'h1_8000_0000;
        upgrade_from_i = 2'h0;
        bus_cmd_outstanding_i = 5'h0;
        victim_cmd_outstanding_i = 3'h0;
        default_memory_type_enable_i = 1'h0;
        phys_addr_i = 64'h0;
        seg_base_i = 64'h0;
        seg_offset_i = 32'h0;
        legacy_mode_i = 1'h0;
        narrow_store_i = 1'h0;
        mc_wdata_nonzero_i = 1'h0;
        idle(8);
        rst_n_i <= 1'h1;
        ext = 64'h0;
        sys = 64'h2_0601;
        hw = 64'h0;
        long_mode_active_flag = 1'h0;
        idle(2);
        chk_levels();
        // reset values, unmapped places, guarded flag
        reg_op(1'h0, FCM_ADDR_EXT_FEAT, 64'h0);
        reg_op(1'h0, FCM_ADDR_SYS_CFG, 64'h0);
        reg_op(1'h0, FCM_ADDR_HW_CFG, 64'h0);
        reg_op(1'h1, 32'hC001_0011, '1);
        reg_op(1'h0, 32'hC000_0081, 64'h0);
        reg_op(1'h1, FCM_ADDR_EXT_FEAT, ~64'h400);
        reg_op(1'h1, FCM_ADDR_EXT_FEAT, 64'h400);
        reg_op(1'h1, FCM_ADDR_SYS_CFG, '1);
        reg_op(1'h1, FCM_ADDR_HW_CFG, '1);
        reg_op(1'h0, FCM_ADDR_EXT_FEAT, 64'h0);
        reg_op(1'h0, FCM_ADDR_SYS_CFG, 64'h0);
        reg_op(1'h0, FCM_ADDR_HW_CFG, 64'h0);
        idle(2);
        chk_levels();
        repeat (20) core_step();
        idle(1);
        reg_op(1'h1, FCM_ADDR_SYS_CFG, 64'h77_07FF);
        idle(2);
        // random traffic with the long mode status toggling now and then
        for (int i = 0; i < 40; i++) begin
            if (i % 10 == 5) begin
                long_mode_active_i <= ~long_mode_active_flag;
                idle(3);
                long_mode_active_flag = ~long_mode_active_flag;
            end
            // fast save stays set; attribute modify stays clear after setup
            reg_op(1'h1, FCM_ADDR_EXT_FEAT,
                {32'($random(seed)), 32'($random(seed))} | 64'h4000);
            reg_op(1'h1, FCM_ADDR_SYS_CFG,
                {32'($random(seed)), 32'($random(seed))} & ~64'h8_0000);
            reg_op(1'h1, FCM_ADDR_HW_CFG,
                {32'($random(seed)), 32'($random(seed))});
            reg_op(1'h0, FCM_ADDR_EXT_FEAT, 64'h0);
            reg_op(1'h0, FCM_ADDR_SYS_CFG, 64'h0);
            reg_op(1'h0, FCM_ADDR_HW_CFG, 64'h0);
            idle(3);
            chk_levels();
            repeat (4) core_step();
            idle(1);
        end
        idle(3);
        if (q_ans.size() != 0 || q_core.size() != 0) bad("results still awaited");
        end_of_test();
    end
endmodule
